// [hdl/angle_sensor_regs.vh]
// Purpose: constants of the angle sensor serial front end
// Assumes: 25 MHz system clock
// Notes: definitions only
`ifndef ANGLE_SENSOR_REGS_VH
`define ANGLE_SENSOR_REGS_VH
// serial frame layout
`define FRAME_BITS 5'h10
`define FRAME_OVER 5'h11
`define FRAME_LAST 15
`define DIR_BIT 15
`define ADDR_HI 14
`define ADDR_LO 1
`define DATA_HI 15
`define DATA_LO 2
`define EF_BIT 1
// serial register addresses
`define ADDR_FETCH 14'h3FFF
`define ADDR_ERR_STATUS 14'h335A
`define ADDR_CLEAR_EF 14'h3380
`define ADDR_POR_DISABLE 14'h3F22
`define ADDR_GAIN 14'h3FF8
// reset values and the por disable key
`define POR_DISABLE_RST 8'h00
`define POR_DISABLE_KEY 8'h5A
`define GAIN_RST 6'h20
`define CONV_RST 16'h0100
// error status fields
`define ERR_PARITY 0
`define ERR_PENDING 1
// timing
`define CLK_FREQ_MHZ 25
`define CONV_MAX_US 500
// avalon word offsets (byte address bits 4:2)
`define OFS_ANGLE_SRC 3'h0
`define OFS_CONV_TIME 3'h1
`define OFS_STATUS 3'h2
`define OFS_ANGLE 3'h3
`define OFS_CONFIG 3'h4
// status register fields
`define ST_BUSY 0
`define ST_PENDING 1
`define ST_PAR_ERR 2
`define ST_EF 3
`define ST_DONE_N 4
`define ST_WIRE4 5
`define ST_POR_ON 6
`endif

// [hdl/angle_sensor_spi_readout.v]
// Purpose: serial slave front end and measurement sequencing
// Assumes: serial pins are asynchronous and sampled at 25 MHz
// Notes: registers reached over Avalon-MM with waitrequest
`default_nettype none
`include "angle_sensor_regs.vh"
module angle_sensor_spi_readout #(
  // longest conversion in system clock cycles
  parameter MAX_CONV_CYCLES = `CONV_MAX_US * `CLK_FREQ_MHZ
) (
  // system
  input wire clock_i,
  input wire rst_b_i,
  // avalon-mm slave
  input wire [4:0] address_i,
  input wire read_i,
  input wire write_i,
  input wire [3:0] byteenable_i,
  input wire [31:0] writedata_i,
  output reg [31:0] readdata_o,
  output reg waitrequest_o,
  // serial pins
  input wire sclk_i,
  input wire frame_select_n_i,
  input wire mosi_i,
  input wire sdio_i,
  input wire wire_mode_select_i,
  output reg miso_o,
  output reg miso_oe_o,
  output reg sdio_o,
  output reg sdio_oe_o,
  // measurement status
  output reg done_n_o,
  output reg low_power_o,
  output reg por_cell_enable_o
);

////////////////////////////////////////////////////////////////////////
// synchronisers: stage a feeds stage b only
reg sck_a, sck_b, sck_c; // serial clock
reg sel_a, sel_b, sel_c; // select, active low
reg mosi_a, mosi_b; // four-wire data in
reg sdio_a, sdio_b; // three-wire data in
reg wm_a, wm_b; // wire mode

// all pins pass two flops before use
always @(posedge clock_i or negedge rst_b_i) begin
  if (!rst_b_i) begin
    sck_a <= 1'b0;
    sck_b <= 1'b0;
    sck_c <= 1'b0;
    sel_a <= 1'b1;
    sel_b <= 1'b1;
    sel_c <= 1'b1;
    mosi_a <= 1'b0;
    mosi_b <= 1'b0;
    sdio_a <= 1'b0;
    sdio_b <= 1'b0;
    wm_a <= 1'b0;
    wm_b <= 1'b0;
  end else begin
    sck_a <= sclk_i; // clock and select only ever inputs
    sck_b <= sck_a;
    sck_c <= sck_b;
    sel_a <= frame_select_n_i;
    sel_b <= sel_a;
    sel_c <= sel_b;
    mosi_a <= mosi_i;
    mosi_b <= mosi_a;
    sdio_a <= sdio_i;
    sdio_b <= sdio_a;
    wm_a <= wire_mode_select_i;
    wm_b <= wm_a;
  end
end

// edge strobes, only from second stage on
wire sck_rise = sck_b & ~sck_c;
wire sck_fall = ~sck_b & sck_c;
wire sel_fall = ~sel_b & sel_c;
wire sel_rise = sel_b & ~sel_c;
wire in_frame = ~sel_b;
// data input follows wire mode
wire rx_bit = wm_b ? mosi_b : sdio_b;

////////////////////////////////////////////////////////////////////////
// register state
reg [15:0] rx_shift; // received bits
reg [15:0] tx_shift; // bits going out
reg [15:0] tx_word; // reply for next frame
reg tx_valid; // next frame carries a reply
reg [4:0] bit_cnt; // falling edges seen
reg wr_pending; // next frame is write data
reg [13:0] wr_addr; // target of pending write
reg [7:0] por_disable; // power-on-reset disable
reg [5:0] gain; // gain setting
reg [13:0] angle; // last result
reg [13:0] angle_src; // result source from core
reg [15:0] conv_time; // conversion length, cycles
reg [15:0] conv_cnt; // remaining cycles
reg busy; // measurement running
reg pending; // measurement pending flag
reg par_err; // parity error seen
reg err_flag; // command frame error

// even parity over the upper fifteen bits
function par15;
  input [15:0] w;
  begin
    par15 = ^w[`FRAME_LAST:1];
  end
endfunction

// serial register read map
function [13:0] peek;
  input [13:0] a;
  begin
    case (a)
      `ADDR_FETCH: peek = angle;
      `ADDR_ERR_STATUS: peek = {12'h000, pending, par_err};
      `ADDR_POR_DISABLE: peek = {6'h00, por_disable};
      `ADDR_GAIN: peek = {8'h00, gain};
      default: peek = 14'h0000;
    endcase
  end
endfunction

// build a reply frame with flag and parity
function [15:0] reply;
  input [13:0] d;
  input ef;
  reg [15:0] t;
  begin
    t = {d, ef, 1'b0};
    reply = {t[15:1], par15(t)};
  end
endfunction

// frame decode terms
wire frame_ok = (bit_cnt == `FRAME_BITS);
wire par_ok = ~(^rx_shift);
wire [13:0] cmd_addr = rx_shift[`ADDR_HI:`ADDR_LO];
wire cmd_read = rx_shift[`DIR_BIT];
wire [13:0] wr_data = rx_shift[`DATA_HI:`DATA_LO];
// three-wire: a frame in which we drive the line only echoes our reply
wire own_echo = ~wm_b & tx_valid;
wire good_frame = sel_rise & frame_ok & par_ok & ~own_echo;
wire bad_frame = sel_rise & frame_ok & ~par_ok & ~own_echo;
wire is_cmd = good_frame & ~wr_pending;
wire fetch = is_cmd & cmd_read & (cmd_addr == `ADDR_FETCH);
wire clr_ef = is_cmd & cmd_read & (cmd_addr == `ADDR_CLEAR_EF);
wire conv_end = busy & (conv_cnt == 16'h0000);
// conversion length capped at the worst case
wire [15:0] conv_max = MAX_CONV_CYCLES[15:0];
wire [15:0] conv_len = (conv_time > conv_max) ? conv_max : conv_time;

////////////////////////////////////////////////////////////////////////
// serial shifting; no edges assumed outside a frame
always @(posedge clock_i or negedge rst_b_i) begin
  if (!rst_b_i) begin
    rx_shift <= 16'h0000;
    tx_shift <= 16'h0000;
    bit_cnt <= 5'h00;
    miso_o <= 1'b0;
    sdio_o <= 1'b0;
  end else if (sel_fall) begin
    bit_cnt <= 5'h00;
    tx_shift <= tx_valid ? tx_word : 16'h0000;
  end else if (in_frame) begin
    if (sck_rise) begin
      // launch on first edge, msb first
      miso_o <= tx_shift[`FRAME_LAST];
      sdio_o <= tx_shift[`FRAME_LAST];
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
    if (sck_fall) begin
      // capture on second edge, msb first
      rx_shift <= {rx_shift[14:0], rx_bit};
      if (bit_cnt != `FRAME_OVER) begin
        bit_cnt <= bit_cnt + 5'h01; // over-long frames pass 16
      end
    end
  end
end

// data line drivers; released between frames
always @(posedge clock_i or negedge rst_b_i) begin
  if (!rst_b_i) begin
    miso_oe_o <= 1'b0;
    sdio_oe_o <= 1'b0;
  end else begin
    // four-wire drives its own output for the whole frame
    miso_oe_o <= in_frame & wm_b;
    // three-wire shares one line, driven only for a reply
    sdio_oe_o <= in_frame & ~wm_b & tx_valid;
  end
end

////////////////////////////////////////////////////////////////////////
// command execution at end of frame only
always @(posedge clock_i or negedge rst_b_i) begin
  if (!rst_b_i) begin
    tx_word <= 16'h0000;
    tx_valid <= 1'b0;
    wr_pending <= 1'b0;
    wr_addr <= 14'h0000;
    por_disable <= `POR_DISABLE_RST;
    gain <= `GAIN_RST;
    par_err <= 1'b0;
    err_flag <= 1'b0;
  end else begin
    if (bad_frame) begin
      // corrupt frame flags error and drops a pending write
      par_err <= 1'b1;
      err_flag <= 1'b1;
      wr_pending <= 1'b0;
      tx_word <= reply(peek(`ADDR_ERR_STATUS), 1'b1);
      tx_valid <= 1'b1;
    end else if (good_frame & wr_pending) begin
      // data frame: store por disable or gain, then echo the new contents
      wr_pending <= 1'b0;
      tx_valid <= 1'b1;
      if (wr_addr == `ADDR_POR_DISABLE) begin
        por_disable <= wr_data[7:0];
        tx_word <= reply({6'h00, wr_data[7:0]}, err_flag);
      end else if (wr_addr == `ADDR_GAIN) begin
        gain <= wr_data[5:0];
        tx_word <= reply({8'h00, wr_data[5:0]}, err_flag);
      end else begin
        tx_word <= reply(peek(wr_addr), err_flag);
      end
    end else if (is_cmd) begin
      // sample addressed register now, send next frame
      tx_word <= reply(peek(cmd_addr), err_flag);
      tx_valid <= 1'b1;
      if (!cmd_read) begin
        wr_pending <= 1'b1;
        wr_addr <= cmd_addr;
      end
      if (clr_ef) begin
        // clear wins only for its own frame; errors stay set until a clear
        par_err <= 1'b0;
        err_flag <= 1'b0;
      end
    end else if (sel_rise) begin
      // short, long or three-wire echo frame: nothing to execute
      tx_valid <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// measurement sequencer
always @(posedge clock_i or negedge rst_b_i) begin
  if (!rst_b_i) begin
    busy <= 1'b0;
    pending <= 1'b0;
    conv_cnt <= 16'h0000;
    angle <= 14'h0000;
    done_n_o <= 1'b1;
    low_power_o <= 1'b1;
  end else if (fetch & ~busy) begin
    // a fetch during a conversion is ignored, not restarted
    busy <= 1'b1;
    pending <= 1'b1;
    done_n_o <= 1'b1;
    low_power_o <= 1'b0;
    conv_cnt <= conv_len;
  end else if (conv_end) begin
    // one result per fetch, then back to low power
    angle <= angle_src;
    busy <= 1'b0;
    pending <= 1'b0;
    done_n_o <= 1'b0;
    low_power_o <= 1'b1;
  end else if (busy) begin
    conv_cnt <= conv_cnt - 16'h0001;
  end
end

// power-on-reset cell stays on unless the key is written
always @(posedge clock_i or negedge rst_b_i) begin
  if (!rst_b_i) begin
    por_cell_enable_o <= 1'b1;
  end else begin
    por_cell_enable_o <= (por_disable != `POR_DISABLE_KEY);
  end
end

////////////////////////////////////////////////////////////////////////
// avalon slave: one wait cycle per access
wire [2:0] word = address_i[4:2];
wire access = read_i | write_i;
wire commit = access & ~waitrequest_o;
wire [31:0] be_mask = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                       {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
wire [31:0] cur_src = {18'h00000, angle_src};
wire [31:0] cur_conv = {16'h0000, conv_time};
wire [31:0] new_src = (cur_src & ~be_mask) | (writedata_i & be_mask);
wire [31:0] new_conv = (cur_conv & ~be_mask) | (writedata_i & be_mask);

// status word seen by software
wire [31:0] status = {25'h0000000, por_cell_enable_o, wm_b,
                      done_n_o, err_flag, par_err, pending, busy};

// read mux; unmapped words read zero
reg [31:0] next_readdata;
always @* begin
  case (word)
    `OFS_ANGLE_SRC: next_readdata = cur_src;
    `OFS_CONV_TIME: next_readdata = cur_conv;
    `OFS_STATUS: next_readdata = status;
    `OFS_ANGLE: next_readdata = {18'h00000, angle};
    `OFS_CONFIG: next_readdata = {18'h00000, gain, por_disable};
    default: next_readdata = 32'h00000000;
  endcase
end

// waitrequest drops one cycle after a request, then rises again
always @(posedge clock_i or negedge rst_b_i) begin
  if (!rst_b_i) begin
    waitrequest_o <= 1'b1;
    readdata_o <= 32'h00000000;
    angle_src <= 14'h0000;
    conv_time <= `CONV_RST;
  end else begin
    waitrequest_o <= ~(access & waitrequest_o);
    if (access & waitrequest_o & read_i) begin
      readdata_o <= next_readdata;
    end
    if (commit & write_i) begin
      // writes take effect at the accepting edge only
      if (word == `OFS_ANGLE_SRC) begin
        angle_src <= new_src[13:0];
      end
      if (word == `OFS_CONV_TIME) begin
        conv_time <= new_conv[15:0];
      end
    end
  end
end

endmodule // angle_sensor_spi_readout
`default_nettype wire

// [verif/angle_sensor_spi_readout_assertions.sv]
// Purpose: port-level checks of the angle sensor readout
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to the design from the bench top file
`default_nettype none
module angle_sensor_spi_readout_assertions #(
  parameter int MAX_CONV_CYCLES = 50
) (
  // system
  input wire logic clock_i,
  input wire logic rst_b_i,
  // avalon handshake
  input wire logic read_i,
  input wire logic write_i,
  input wire logic waitrequest_o,
  // serial pins and status
  input wire logic frame_select_n_i,
  input wire logic miso_oe_o,
  input wire logic sdio_oe_o,
  input wire logic done_n_o,
  input wire logic low_power_o
);
  // slack covers pin synchronisers and output registers
  localparam int LIM = MAX_CONV_CYCLES + 16;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////
  // an access is taken while waitrequest still stands high
  sequence s_req;
    (read_i || write_i) && waitrequest_o;
  endsequence
  // a fetch has woken the sensor
  sequence s_start;
    $rose(done_n_o);
  endsequence
  AST_WAIT_CAUSE: assert property (s_req |=> !waitrequest_o)
    else $error("access not answered in the next cycle");
  AST_WAIT_ONE: assert property ($fell(waitrequest_o) |=>
    waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  AST_OE_RELEASE: assert property (frame_select_n_i[*5] |->
    !miso_oe_o && !sdio_oe_o)
    else $error("data line driven while deselected");
  AST_OE_EXCL: assert property (!(miso_oe_o && sdio_oe_o))
    else $error("both data pins driven");
  AST_WAKE: assert property (s_start |-> !low_power_o)
    else $error("fetch did not leave low power");
  AST_SLEEP: assert property ($fell(done_n_o) |-> low_power_o)
    else $error("no low power after completion");
  AST_CONV_BOUND: assert property (s_start |->
    ##[1:LIM] !done_n_o)
    else $error("measurement overran its time");
  AST_NO_MIDFRAME: assert property ((!frame_select_n_i)[*6] |->
    !$rose(done_n_o))
    else $error("command acted inside a frame");
endmodule // angle_sensor_spi_readout_assertions
`default_nettype wire

// [verif/spi_host_model.sv]
// Purpose: host acting as serial master, mode 1
// Assumes: link clock period 320 ns, stopped between frames
// Notes: frames are started by the bench through xfer
`default_nettype none
module spi_host_model (
  // resolved device-to-host data; a single sensor
  input wire logic din_i,
  // pins driven by the host
  output logic sclk_o,
  output logic sel_n_o,
  output logic mosi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////
  // clock idles low, select idles high
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // one frame at 3.125 MHz
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    r = '0;
    #7; // keeps the link phase apart from the system clock
    sel_n_o = 1'b0; // clock held low here
    #160;
    for (int i = 15; i >= 0; i--) begin // msb first
      sclk_o = 1'b1;
      mosi_o = w[i]; // launch on the rising edge
      #160;
      r = {r[14:0], din_i}; // capture on the falling edge
      sclk_o = 1'b0;
      #160;
    end
    sel_n_o = 1'b1;
    mosi_o = ~mosi_o; // a released line shows no stale bit
    #400;
  endtask
endmodule // spi_host_model
`default_nettype wire

// [verif/tb.sv]
// Purpose: self-checking bench of the angle sensor readout
// Assumes: 25 MHz clock, short conversion parameter
// Notes: avalon tasks drive the registers, host model the link
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CONV = 50; // short conversion keeps the run brief
  localparam int STARTUP_TIME = 20; // startup_time, scaled like CONV
  logic clock_i, rst_b_i, read_i, write_i, wm;
  logic [4:0] address_i;
  logic [31:0] writedata_i, readdata_o;
  logic waitrequest_o, sclk, sel_n, mosi, sdio_i, din;
  logic miso_o, miso_oe_o, sdio_o, sdio_oe_o;
  logic done_n_o, low_power_o, por_cell_enable_o;
  int fails = 0, checks = 0, cyc = 0;
  typedef struct {logic [4:0] a; logic [31:0] e;} row_t;
  // reset view of each word: status, angle, config, two unmapped
  row_t rows [5] = '{'{5'h08, 32'h70}, '{5'h0C, 32'h0},
    '{5'h10, 32'h2000}, '{5'h14, 32'h0}, '{5'h1C, 32'h0}};
  // device wins the shared line when it drives
  assign sdio_i = sdio_oe_o ? sdio_o : mosi;
  assign din = wm ? (miso_oe_o ? miso_o : ~mosi) : sdio_i;
  angle_sensor_spi_readout #(.MAX_CONV_CYCLES(CONV))
    i_angle_sensor_spi_readout (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .byteenable_i(4'hF), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .sclk_i(sclk), .frame_select_n_i(sel_n), .mosi_i(mosi),
    .sdio_i(sdio_i), .wire_mode_select_i(wm), .miso_o(miso_o),
    .miso_oe_o(miso_oe_o), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o),
    .done_n_o(done_n_o), .low_power_o(low_power_o),
    .por_cell_enable_o(por_cell_enable_o));
  spi_host_model i_spi_host_model (.din_i(din), .sclk_o(sclk),
    .sel_n_o(sel_n), .mosi_o(mosi));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  // hang guard, far beyond the expected few thousand cycles
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  // frame with even parity in bit zero
  function automatic logic [15:0] fr(input logic [14:0] u);
    return {u, ^u};
  endfunction
  // one avalon access, held until waitrequest is sampled low
  task automatic av(input logic w, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    address_i <= a;
    writedata_i <= d;
    write_i <= w;
    read_i <= !w;
    // no limit of its own; only the hang guard ends a stuck wait
    do begin
      @(posedge clock_i);
    end while (waitrequest_o !== 1'b0);
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask
  // bounded wait for completion
  task automatic wait_done();
    int n = 0;
    while (done_n_o !== 1'b0 && n < 200) begin
      @(posedge clock_i);
      n++;
    end
    `CHK("done in time", 1'b1, n < 200)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic [15:0] r;
    rst_b_i = 1'b0;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = '0;
    writedata_i = '0;
    wm = 1'b1;
    repeat (10) @(posedge clock_i);
    rst_b_i <= 1'b1;
    // pins pass their synchronisers before status shows the wire mode
    repeat (STARTUP_TIME) @(posedge clock_i);
    foreach (rows[k]) begin
      av(1'b0, rows[k].a, '0, q);
      `CHK("reset word", rows[k].e, q)
    end
    $display("test reset_values done");
    // fetch twice; the second reply carries the first result
    av(1'b1, 5'h00, 32'h1234, q);
    i_spi_host_model.xfer(fr({1'b1, 14'h3FFF}), r);
    `CHK("done_n busy", 1'b1, done_n_o)
    `CHK("low_power busy", 1'b0, low_power_o)
    wait_done(); // host waits for done
    av(1'b0, 5'h08, '0, q);
    `CHK("status idle", 32'h60, q)
    i_spi_host_model.xfer(fr({1'b1, 14'h3FFF}), r);
    wait_done();
    i_spi_host_model.xfer(fr({1'b1, 14'h335A}), r);
    `CHK("angle reply", fr({14'h1234, 1'b0}), r)
    repeat (100) @(posedge clock_i);
    `CHK("single run", 1'b0, done_n_o)
    $display("test fetch done");
    // write 5A to por disable: old value, then the new one
    i_spi_host_model.xfer(fr({1'b0, 14'h3F22}), r);
    i_spi_host_model.xfer(fr({14'h005A, 1'b0}), r);
    `CHK("old reply", 16'h0000, r)
    i_spi_host_model.xfer(fr({1'b1, 14'h3F22}), r);
    `CHK("new reply", fr({14'h005A, 1'b0}), r)
    `CHK("por cell off", 1'b0, por_cell_enable_o)
    av(1'b0, 5'h10, '0, q);
    `CHK("config", 32'h205A, q)
    $display("test por_write done");
    // bad parity flags an error, clear read removes it
    i_spi_host_model.xfer(fr({1'b1, 14'h3F22}) ^ 16'h1, r);
    av(1'b0, 5'h08, '0, q);
    `CHK("parity flagged", 32'h2C, q)
    i_spi_host_model.xfer(fr({1'b1, 14'h3380}), r);
    av(1'b0, 5'h08, '0, q);
    `CHK("flags cleared", 32'h20, q)
    $display("test parity done");
    // three-wire: a reply frame owns the shared line, so the device
    // listens only in the frame after it
    @(posedge clock_i);
    wm <= 1'b0;
    repeat (5) @(posedge clock_i);
    i_spi_host_model.xfer(fr({1'b1, 14'h3F22}), r);
    `CHK("error reply", fr({14'h0000, 1'b1}), r)
    i_spi_host_model.xfer(fr({1'b1, 14'h3F22}), r);
    i_spi_host_model.xfer(fr({1'b1, 14'h3F22}), r);
    `CHK("three wire reply", fr({14'h005A, 1'b0}), r)
    $display("test three_wire done");
    // second reset mid-run restores defaults
    rst_b_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    `CHK("por cell on", 1'b1, por_cell_enable_o)
    `CHK("done_n reset", 1'b1, done_n_o)
    `CHK("wait reset", 1'b1, waitrequest_o)
    `CHK("readdata reset", 32'h0, readdata_o)
    rst_b_i <= 1'b1;
    av(1'b0, 5'h10, '0, q);
    `CHK("config reset", 32'h2000, q)
    $display("test second_reset done");
    tally_and_finish();
  end
endmodule // tb
bind angle_sensor_spi_readout angle_sensor_spi_readout_assertions #(
  .MAX_CONV_CYCLES(MAX_CONV_CYCLES)) i_chk (.clock_i(clock_i),
  .rst_b_i(rst_b_i), .read_i(read_i), .write_i(write_i),
  .waitrequest_o(waitrequest_o), .frame_select_n_i(frame_select_n_i),
  .miso_oe_o(miso_oe_o), .sdio_oe_o(sdio_oe_o), .done_n_o(done_n_o),
  .low_power_o(low_power_o));
`default_nettype wire
